// *** dic_cap_if.sv ***
// signals between the conditioning core and the capture unit
`timescale 1ns/1ns
interface dic_cap_if;
	logic wr_mode;
	logic wr_count;
	logic wr_value;
	logic wr_raw;
	dic_pkg::dic_word_t wdata;
	logic level;
	dic_pkg::dic_word_t pos_user;
	dic_pkg::dic_word_t pos_raw;
	dic_pkg::dic_cap_mode_t mode;
	dic_pkg::dic_word_t count;
	dic_pkg::dic_word_t value;
	dic_pkg::dic_word_t raw;
	modport core (output wr_mode, wr_count, wr_value, wr_raw, wdata, level, pos_user, pos_raw,
		input mode, count, value, raw);
	modport unit (input wr_mode, wr_count, wr_value, wr_raw, wdata, level, pos_user, pos_raw,
		output mode, count, value, raw);
endinterface

// *** dic_capture.sv ***
// position capture on level changes of input 2
`timescale 1ns/1ns
`include "dic_consts.svh"
module dic_capture
(
	input wire logic clk_sys, // system clock
	input wire logic arst_n, // async reset, active low
	dic_cap_if.unit cap // core side
);
	logic prev;
	logic primed;
	logic edge_rise;
	logic edge_fall;
	logic hit;

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	// primed blocks a false edge from the reset value of prev
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prev <= 1'b0;
			primed <= 1'b0;
		end
		else
		begin
			prev <= cap.level;
			primed <= 1'b1;
		end
	end

	assign edge_rise = primed & cap.level & ~prev;
	assign edge_fall = primed & ~cap.level & prev;

	// trigger select by mode
	always_comb
	begin
		case (cap.mode)
			dic_pkg::dic_cap_off: hit = 1'b0;
			dic_pkg::dic_cap_rise: hit = edge_rise;
			dic_pkg::dic_cap_fall: hit = edge_fall;
			dic_pkg::dic_cap_both: hit = edge_rise | edge_fall;
			default: hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// capture registers
	// ----------------------------------------
	// mode register
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			cap.mode <= dic_pkg::dic_cap_off;
		else if (cap.wr_mode)
			cap.mode <= dic_pkg::dic_cap_mode_t'(cap.wdata[1:0]);
	end

	// counter: a capture in the clearing cycle still counts
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			cap.count <= `DIC_WORD_RST;
		else if (cap.wr_mode && cap.wdata[1:0] != 2'b00)
			cap.count <= hit ? 32'h0000_0001 : `DIC_WORD_RST;
		else if (hit)
			cap.count <= cap.count + 32'h0000_0001;
		else if (cap.wr_count)
			cap.count <= cap.wdata;
	end

	// positions: capture wins over a software write
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cap.value <= `DIC_WORD_RST;
			cap.raw <= `DIC_WORD_RST;
		end
		else
		begin
			if (hit)
				cap.value <= cap.pos_user;
			else if (cap.wr_value)
				cap.value <= cap.wdata;
			if (hit)
				cap.raw <= cap.pos_raw;
			else if (cap.wr_raw)
				cap.raw <= cap.wdata;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_cap_rise_only: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(cap.mode == dic_pkg::dic_cap_rise && edge_fall && !cap.wr_mode && !cap.wr_value)
		|=> cap.value == $past(cap.value))
		else $error("capture fired on falling edge in rise mode");
	a_cap_pos_taken: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(hit) |=> (cap.value == $past(cap.pos_user) && cap.raw == $past(cap.pos_raw)))
		else $error("positions not captured on a hit");
	a_cap_count_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(cap.wr_mode && cap.wdata[1:0] != 2'b00 && !hit) |=> cap.count == 32'h0000_0000)
		else $error("count not cleared by mode write");
	a_cap_count_step: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(hit && !cap.wr_mode) |=> cap.count == $past(cap.count) + 32'h0000_0001)
		else $error("count did not step on capture");
endmodule

// *** dic_consts.svh ***
// constants for the digital input conditioning block
`ifndef DIC_CONSTS_SVH
`define DIC_CONSTS_SVH

// object indices
`define DIC_IDX_CTRL 16'h3240
`define DIC_IDX_CAPT 16'h3241

// subindices of the control object
`define DIC_SUB_ENTRIES 8'h00
`define DIC_SUB_SF_EN 8'h01
`define DIC_SUB_INVERT 8'h02
`define DIC_SUB_SIM_EN 8'h03
`define DIC_SUB_SIM_VAL 8'h04
`define DIC_SUB_RAW 8'h05
`define DIC_SUB_THRESH 8'h06
`define DIC_SUB_DIFF 8'h07
`define DIC_SUB_ROUTE 8'h08

// subindices of the capture object
`define DIC_SUB_CAP_MODE 8'h01
`define DIC_SUB_CAP_COUNT 8'h02
`define DIC_SUB_CAP_VALUE 8'h03
`define DIC_SUB_CAP_RAW 8'h04

// reset values
`define DIC_CTRL_ENTRIES 8'h08
`define DIC_CAPT_ENTRIES 8'h04
`define DIC_WORD_RST 32'h0000_0000

// field positions
`define DIC_SF_LSB 0
`define DIC_SF_MSB 15
`define DIC_LVL_LSB 16
`define DIC_LVL_MSB 31
`define DIC_BIT_NEG_LIMIT 0
`define DIC_BIT_POS_LIMIT 1
`define DIC_BIT_HOME 2
`define DIC_CAP_LVL_BIT 17

`endif

// *** dic_pkg.sv ***
// types shared by the digital input conditioning block
package dic_pkg;
	typedef logic [31:0] dic_word_t;
	typedef enum logic [1:0]
	{
		dic_cap_off = 2'b00,
		dic_cap_rise = 2'b01,
		dic_cap_fall = 2'b10,
		dic_cap_both = 2'b11
	} dic_cap_mode_t;
endpackage

// *** dic_top.sv ***
// digital input conditioning: configuration object, summary word and capture
`timescale 1ns/1ns
`include "dic_consts.svh"
module dic_top
#(
	parameter int N_IN = 16, // physical inputs
	parameter logic [31:0] CLKDIR_MASK = 32'h0000_0000 // inputs used as clock/direction
)
(
	input wire logic clk_sys, // system clock, 250 MHz
	input wire logic arst_n, // async reset, active low
	input wire logic [N_IN-1:0] din_pin, // physical input levels, asynchronous
	input wire logic clkdir_active, // clock/direction mode is running
	input wire logic [31:0] enc_pos_user, // encoder position, user units
	input wire logic [31:0] enc_pos_raw, // encoder position, raw count
	input wire logic obj_wr, // object write strobe
	input wire logic obj_rd, // object read strobe
	input wire logic [15:0] obj_index, // object index
	input wire logic [7:0] obj_sub, // object subindex
	input wire logic [31:0] obj_wdata, // write data
	output logic [31:0] obj_rdata, // read data
	output logic obj_rvalid, // read data valid, one cycle
	output logic obj_err, // access refused, one cycle
	output logic [31:0] din_summary, // conditioned summary word
	output logic limit_neg, // negative limit active
	output logic limit_pos, // positive limit active
	output logic home_sw, // home switch active
	output logic [31:0] thresh_sel, // per input: 0 = 5 V, 1 = 24 V
	output logic [31:0] diff_sel // per input: 0 = single-ended, 1 = differential
);
	dic_pkg::dic_word_t sf_en;
	dic_pkg::dic_word_t invert;
	dic_pkg::dic_word_t sim_en;
	dic_pkg::dic_word_t sim_val;
	dic_pkg::dic_word_t route_en;
	logic [N_IN-1:0] pin_meta;
	logic [N_IN-1:0] pin_sync;
	dic_pkg::dic_word_t raw_word;
	dic_pkg::dic_word_t inv_eff;
	dic_pkg::dic_word_t next_summary;
	logic hit_ctrl;
	logic hit_capt;
	logic rd_ok;
	logic wr_ok;
	dic_pkg::dic_word_t next_rdata;

	dic_cap_if cap ();

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// conditioning chain, kept in one place so the stage order cannot drift
	function automatic dic_pkg::dic_word_t cond_word(input dic_pkg::dic_word_t raw,
		input dic_pkg::dic_word_t fen, input dic_pkg::dic_word_t fval,
		input dic_pkg::dic_word_t inv, input dic_pkg::dic_word_t sfe);
		dic_pkg::dic_word_t w;
		w = (raw & ~fen) | (fval & fen);
		w = w ^ inv;
		w[`DIC_SF_MSB:`DIC_SF_LSB] = w[`DIC_SF_MSB:`DIC_SF_LSB] & sfe[`DIC_SF_MSB:`DIC_SF_LSB];
		return w;
	endfunction

	// widen the pin vector to one half-word
	function automatic logic [15:0] half(input logic [N_IN-1:0] p);
		logic [15:0] h;
		h = 16'h0000;
		for (int i = 0; i < N_IN && i < 16; i++)
			h[i] = p[i];
		return h;
	endfunction

	// ----------------------------------------
	// input synchroniser
	// ----------------------------------------
	// pins are asynchronous; two stages before anything looks at them
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_meta <= '0;
			pin_sync <= '0;
		end
		else
		begin
			pin_meta <= din_pin;
			pin_sync <= pin_meta;
		end
	end

	// ----------------------------------------
	// conditioning path
	// ----------------------------------------
	// the same pin feeds its special-function bit and its level bit
	assign raw_word = {half(pin_sync), half(pin_sync)};
	// clock/direction inputs bypass inversion while that mode runs
	assign inv_eff = clkdir_active ? (invert & ~CLKDIR_MASK) : invert;
	assign next_summary = cond_word(raw_word, sim_en, sim_val, inv_eff, sf_en);

	// summary word and special function outputs
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			din_summary <= `DIC_WORD_RST;
			limit_neg <= 1'b0;
			limit_pos <= 1'b0;
			home_sw <= 1'b0;
		end
		else
		begin
			din_summary <= next_summary;
			limit_neg <= next_summary[`DIC_BIT_NEG_LIMIT];
			limit_pos <= next_summary[`DIC_BIT_POS_LIMIT];
			home_sw <= next_summary[`DIC_BIT_HOME];
		end
	end

	// ----------------------------------------
	// object access decode
	// ----------------------------------------
	assign hit_ctrl = obj_index == `DIC_IDX_CTRL;
	assign hit_capt = obj_index == `DIC_IDX_CAPT;
	// subindex 0 of each object is read only
	assign wr_ok = (hit_ctrl && obj_sub >= `DIC_SUB_SF_EN && obj_sub <= `DIC_SUB_ROUTE)
		|| (hit_capt && obj_sub >= `DIC_SUB_CAP_MODE && obj_sub <= `DIC_SUB_CAP_RAW);
	assign rd_ok = (hit_ctrl && obj_sub <= `DIC_SUB_ROUTE) || (hit_capt && obj_sub <= `DIC_SUB_CAP_RAW);

	// configuration words; raw word writes are accepted and dropped
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sf_en <= `DIC_WORD_RST;
			invert <= `DIC_WORD_RST;
			sim_en <= `DIC_WORD_RST;
			sim_val <= `DIC_WORD_RST;
			thresh_sel <= `DIC_WORD_RST;
			diff_sel <= `DIC_WORD_RST;
			route_en <= `DIC_WORD_RST;
		end
		else if (obj_wr && hit_ctrl)
		begin
			case (obj_sub)
				`DIC_SUB_SF_EN: sf_en <= obj_wdata;
				`DIC_SUB_INVERT: invert <= obj_wdata;
				`DIC_SUB_SIM_EN: sim_en <= obj_wdata;
				`DIC_SUB_SIM_VAL: sim_val <= obj_wdata;
				`DIC_SUB_THRESH: thresh_sel <= obj_wdata;
				`DIC_SUB_DIFF: diff_sel <= obj_wdata;
				`DIC_SUB_ROUTE: route_en <= obj_wdata;
				default: ;
			endcase
		end
	end

	// capture unit strobes
	assign cap.wr_mode = obj_wr && hit_capt && obj_sub == `DIC_SUB_CAP_MODE;
	assign cap.wr_count = obj_wr && hit_capt && obj_sub == `DIC_SUB_CAP_COUNT;
	assign cap.wr_value = obj_wr && hit_capt && obj_sub == `DIC_SUB_CAP_VALUE;
	assign cap.wr_raw = obj_wr && hit_capt && obj_sub == `DIC_SUB_CAP_RAW;
	assign cap.wdata = obj_wdata;
	// conditioned level of input 2, so forcing and inversion apply to capture
	assign cap.level = din_summary[`DIC_CAP_LVL_BIT];
	assign cap.pos_user = enc_pos_user;
	assign cap.pos_raw = enc_pos_raw;

	dic_capture u_capture
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.cap(cap)
	);

	// read mux
	always_comb
	begin
		next_rdata = `DIC_WORD_RST;
		if (hit_ctrl)
		begin
			case (obj_sub)
				`DIC_SUB_ENTRIES: next_rdata = {24'h00_0000, `DIC_CTRL_ENTRIES};
				`DIC_SUB_SF_EN: next_rdata = sf_en;
				`DIC_SUB_INVERT: next_rdata = invert;
				`DIC_SUB_SIM_EN: next_rdata = sim_en;
				`DIC_SUB_SIM_VAL: next_rdata = sim_val;
				`DIC_SUB_RAW: next_rdata = raw_word;
				`DIC_SUB_THRESH: next_rdata = thresh_sel;
				`DIC_SUB_DIFF: next_rdata = diff_sel;
				`DIC_SUB_ROUTE: next_rdata = route_en;
				default: next_rdata = `DIC_WORD_RST;
			endcase
		end
		else if (hit_capt)
		begin
			case (obj_sub)
				`DIC_SUB_ENTRIES: next_rdata = {24'h00_0000, `DIC_CAPT_ENTRIES};
				`DIC_SUB_CAP_MODE: next_rdata = {30'h0000_0000, cap.mode};
				`DIC_SUB_CAP_COUNT: next_rdata = cap.count;
				`DIC_SUB_CAP_VALUE: next_rdata = cap.value;
				`DIC_SUB_CAP_RAW: next_rdata = cap.raw;
				default: next_rdata = `DIC_WORD_RST;
			endcase
		end
	end

	// read answer one cycle after the strobe; unknown entries flag an error
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			obj_rdata <= `DIC_WORD_RST;
			obj_rvalid <= 1'b0;
			obj_err <= 1'b0;
		end
		else
		begin
			obj_rdata <= (obj_rd && rd_ok) ? next_rdata : `DIC_WORD_RST;
			obj_rvalid <= obj_rd && rd_ok;
			obj_err <= (obj_rd && !rd_ok) || (obj_wr && !wr_ok);
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	// level bit of input 1 is the one the bench forces
	a_force_level_sub: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(sim_en[16]) |=> din_summary[16] == $past(sim_val[16] ^ inv_eff[16]))
		else $error("forced level not used");
	a_invert_high_in: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(!sim_en[16] && raw_word[16] && inv_eff[16]) |=> !din_summary[16])
		else $error("inverted high level not shown as 0");
	a_plain_high_in: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(!sim_en[16] && raw_word[16] && !invert[16]) |=> din_summary[16])
		else $error("high level not shown as 1");
	a_sf_gate_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(!sf_en[`DIC_BIT_NEG_LIMIT] && !sf_en[`DIC_BIT_POS_LIMIT]) |=> (!limit_neg && !limit_pos))
		else $error("disabled limit function reacted");
	a_level_ungated: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(!sim_en[17] && !inv_eff[17]) |=> din_summary[17] == $past(raw_word[17]))
		else $error("level bit changed by enable word");
	a_limit_follows: assert property (@(posedge clk_sys) disable iff (!arst_n)
		1'b1 |-> (limit_neg == din_summary[0] && limit_pos == din_summary[1] && home_sw == din_summary[2]))
		else $error("limit outputs disagree with summary");
	a_entry_count: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(obj_rd && hit_ctrl && obj_sub == `DIC_SUB_ENTRIES) |=> (obj_rvalid && obj_rdata == 32'h0000_0008))
		else $error("entry count not eight");
	a_route_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(obj_wr && hit_ctrl && obj_sub == `DIC_SUB_ROUTE) ##1 !obj_wr
		##1 (obj_rd && hit_ctrl && obj_sub == `DIC_SUB_ROUTE && !obj_wr)
		|=> obj_rdata == $past(obj_wdata, 3))
		else $error("routing word not read back");

	// forcing, gating and clock/direction exemption on the low half
	a_force_low_half: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(sim_en[`DIC_BIT_POS_LIMIT] && sf_en[`DIC_BIT_POS_LIMIT])
		|=> limit_pos == $past(sim_val[`DIC_BIT_POS_LIMIT] ^ inv_eff[`DIC_BIT_POS_LIMIT]))
		else $error("forced limit level not used");
	a_home_gated: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(!sf_en[`DIC_BIT_HOME]) |=> !home_sw)
		else $error("disabled home function reacted");
	a_low_half_gated: assert property (@(posedge clk_sys) disable iff (!arst_n)
		1'b1 |=> (din_summary[`DIC_SF_MSB:`DIC_SF_LSB] & ~$past(sf_en[`DIC_SF_MSB:`DIC_SF_LSB])) == 16'h0000)
		else $error("special function bit set while disabled");
	// an enabled, unforced clock/direction input keeps its plain level while that mode runs
	a_clkdir_no_invert: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(clkdir_active && CLKDIR_MASK[3] && !sim_en[3] && sf_en[3]) |=> din_summary[3] == $past(raw_word[3]))
		else $error("clock/direction input was inverted");

	// object port checks
	a_thresh_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(obj_wr && hit_ctrl && obj_sub == `DIC_SUB_THRESH) |=> thresh_sel == $past(obj_wdata))
		else $error("threshold select not written");
	a_diff_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(obj_wr && hit_ctrl && obj_sub == `DIC_SUB_DIFF) |=> diff_sel == $past(obj_wdata))
		else $error("differential select not written");
	a_raw_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(obj_rd && hit_ctrl && obj_sub == `DIC_SUB_RAW) |=> (obj_rvalid && obj_rdata == $past(raw_word)))
		else $error("raw levels not read back");
	a_ro_write_refused: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(obj_wr && hit_ctrl && obj_sub == `DIC_SUB_ENTRIES) |=> obj_err)
		else $error("write to entry count not refused");
endmodule

// *** dic_top_tb.sv ***
// self-checking testbench for the digital input conditioning block
`timescale 1ns/1ns
`include "dic_consts.svh"

`define CHK(nm, ex, got) \
	begin \
		tests_run++; \
		if ((got) !== (ex)) \
		begin \
			num_errors++; \
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
		end \
	end

module dic_top_tb;
	// ----------------------------------------
	// signals and bench state
	// ----------------------------------------
	localparam logic [31:0] CD_MASK = 32'h0000_0008;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [15:0] din_pin = 16'h0000;
	logic clkdir_active = 1'b0;
	logic [31:0] enc_pos_user = 32'h0000_0000;
	logic [31:0] enc_pos_raw = 32'h0000_0000;
	logic obj_wr = 1'b0;
	logic obj_rd = 1'b0;
	logic [15:0] obj_index = 16'h0000;
	logic [7:0] obj_sub = 8'h00;
	logic [31:0] obj_wdata = 32'h0000_0000;
	logic [31:0] obj_rdata;
	logic obj_rvalid;
	logic obj_err;
	logic [31:0] din_summary;
	logic limit_neg;
	logic limit_pos;
	logic home_sw;
	logic [31:0] thresh_sel;
	logic [31:0] diff_sel;
	int num_errors = 0;
	int tests_run = 0;
	// conditioning cases: pins, enable, invert, force enable, force value, clock/direction
	logic [15:0] t_p [5] = '{16'h0005, 16'h0005, 16'h0005, 16'h00f0, 16'h000d};
	logic [31:0] t_se [5] = '{32'h0000_0000, 32'h0000_0007, 32'hffff_ffff, 32'h0000_00ff, 32'hffff_ffff};
	logic [31:0] t_inv [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0002_0003, 32'h0000_0002, 32'hffff_ffff};
	logic [31:0] t_fe [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0001_0003, 32'h0000_0000};
	logic [31:0] t_fv [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0002, 32'h0000_0000};
	logic t_cd [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	logic [1:0] t_mode [5] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b00};

	// ----------------------------------------
	// design, clock and hang guard
	// ----------------------------------------
	dic_top #(.N_IN(16), .CLKDIR_MASK(CD_MASK)) i_dut
	(
		.clk_sys(clk_sys), .arst_n(arst_n), .din_pin(din_pin), .clkdir_active(clkdir_active),
		.enc_pos_user(enc_pos_user), .enc_pos_raw(enc_pos_raw), .obj_wr(obj_wr), .obj_rd(obj_rd),
		.obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
		.obj_rvalid(obj_rvalid), .obj_err(obj_err), .din_summary(din_summary), .limit_neg(limit_neg),
		.limit_pos(limit_pos), .home_sw(home_sw), .thresh_sel(thresh_sel), .diff_sel(diff_sel)
	);

	// free-running system clock, 4 ns period
	initial
	begin
		forever #2 clk_sys = ~clk_sys;
	end

	// a stuck sequence must still reach the verdict
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		wrap_up();
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic wrap_up();
		if (num_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// one object access; answer and refusal both stand only in the cycle after the taking edge
	task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
		input logic e, output logic [31:0] rd);
		@(posedge clk_sys);
		obj_wr <= w;
		obj_rd <= ~w;
		obj_index <= idx;
		obj_sub <= sub;
		obj_wdata <= wd;
		@(posedge clk_sys);
		obj_wr <= 1'b0;
		obj_rd <= 1'b0;
		#1;
		`CHK("obj_err", e, obj_err)
		if (!w && !e)
			`CHK("obj_rvalid", 1'b1, obj_rvalid)
		rd = obj_rdata;
	endtask

	task automatic rdchk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] ex);
		logic [31:0] d;
		xfer(1'b0, idx, sub, 32'h0000_0000, 1'b0, d);
		`CHK("obj_rdata", ex, d)
	endtask

	// expected summary: raw, force, invert, then enable gating on the low half
	function automatic logic [31:0] cond(input logic [15:0] p, input logic [31:0] se, input logic [31:0] inv,
		input logic [31:0] fe, input logic [31:0] fv, input logic cd);
		logic [31:0] r;
		r = {p, p};
		r = (r & ~fe) | (fv & fe);
		r = r ^ (cd ? (inv & ~CD_MASK) : inv);
		r[15:0] = r[15:0] & se[15:0];
		return r;
	endfunction

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] d;
		logic [31:0] ex;
		logic [31:0] ec;
		logic [31:0] ev;
		logic [31:0] er;
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		tick(1);
		// reset values of both objects
		rdchk(`DIC_IDX_CTRL, `DIC_SUB_ENTRIES, 32'h0000_0008);
		for (int s = 1; s <= 8; s++)
			rdchk(`DIC_IDX_CTRL, 8'(s), `DIC_WORD_RST);
		rdchk(`DIC_IDX_CAPT, `DIC_SUB_ENTRIES, 32'h0000_0004);
		for (int s = 1; s <= 4; s++)
			rdchk(`DIC_IDX_CAPT, 8'(s), `DIC_WORD_RST);
		// refused accesses leave the entry count alone
		xfer(1'b1, `DIC_IDX_CTRL, `DIC_SUB_ENTRIES, 32'h0000_0003, 1'b1, d);
		xfer(1'b1, `DIC_IDX_CTRL, 8'h09, 32'h0000_0003, 1'b1, d);
		xfer(1'b0, 16'h3243, 8'h01, 32'h0000_0000, 1'b1, d);
		rdchk(`DIC_IDX_CTRL, `DIC_SUB_ENTRIES, 32'h0000_0008);
		// plain stored words read back, selects reach their outputs
		xfer(1'b1, `DIC_IDX_CTRL, `DIC_SUB_THRESH, 32'ha5a5_0f0f, 1'b0, d);
		xfer(1'b1, `DIC_IDX_CTRL, `DIC_SUB_DIFF, 32'h5a5a_f0f0, 1'b0, d);
		xfer(1'b1, `DIC_IDX_CTRL, `DIC_SUB_ROUTE, 32'h1234_5678, 1'b0, d);
		rdchk(`DIC_IDX_CTRL, `DIC_SUB_ROUTE, 32'h1234_5678);
		rdchk(`DIC_IDX_CTRL, `DIC_SUB_THRESH, 32'ha5a5_0f0f);
		rdchk(`DIC_IDX_CTRL, `DIC_SUB_DIFF, 32'h5a5a_f0f0);
		`CHK("thresh_sel", 32'ha5a5_0f0f, thresh_sel)
		`CHK("diff_sel", 32'h5a5a_f0f0, diff_sel)
		// conditioning table
		for (int c = 0; c < 5; c++)
		begin
			xfer(1'b1, `DIC_IDX_CTRL, `DIC_SUB_SF_EN, t_se[c], 1'b0, d);
			xfer(1'b1, `DIC_IDX_CTRL, `DIC_SUB_INVERT, t_inv[c], 1'b0, d);
			xfer(1'b1, `DIC_IDX_CTRL, `DIC_SUB_SIM_EN, t_fe[c], 1'b0, d);
			xfer(1'b1, `DIC_IDX_CTRL, `DIC_SUB_SIM_VAL, t_fv[c], 1'b0, d);
			@(posedge clk_sys);
			din_pin <= t_p[c];
			clkdir_active <= t_cd[c];
			tick(5);
			ex = cond(t_p[c], t_se[c], t_inv[c], t_fe[c], t_fv[c], t_cd[c]);
			`CHK("din_summary", ex, din_summary)
			`CHK("limit_neg", ex[0], limit_neg)
			`CHK("limit_pos", ex[1], limit_pos)
			`CHK("home_sw", ex[2], home_sw)
			xfer(1'b1, `DIC_IDX_CTRL, `DIC_SUB_RAW, 32'hffff_ffff, 1'b0, d);
			rdchk(`DIC_IDX_CTRL, `DIC_SUB_RAW, {t_p[c], t_p[c]});
		end
		// back to plain levels for the capture runs
		xfer(1'b1, `DIC_IDX_CTRL, `DIC_SUB_INVERT, 32'h0000_0000, 1'b0, d);
		@(posedge clk_sys);
		din_pin <= 16'h0000;
		clkdir_active <= 1'b0;
		tick(8);
		ec = 32'h0000_0000;
		ev = 32'h0000_0000;
		er = 32'h0000_0000;
		// capture on input 2, every mode, off both first and last
		for (int m = 0; m < 5; m++)
		begin
			xfer(1'b1, `DIC_IDX_CAPT, `DIC_SUB_CAP_MODE, {30'h0, t_mode[m]}, 1'b0, d);
			if (t_mode[m] != 2'b00)
				ec = 32'h0000_0000;
			rdchk(`DIC_IDX_CAPT, `DIC_SUB_CAP_COUNT, ec);
			@(posedge clk_sys);
			enc_pos_user <= 32'h1000_0000 + m;
			enc_pos_raw <= 32'h3000_0000 + m;
			din_pin <= 16'h0002;
			tick(8);
			if (t_mode[m][0])
			begin
				ec++;
				ev = 32'h1000_0000 + m;
				er = 32'h3000_0000 + m;
			end
			@(posedge clk_sys);
			enc_pos_user <= 32'h2000_0000 + m;
			enc_pos_raw <= 32'h4000_0000 + m;
			din_pin <= 16'h0000;
			tick(8);
			if (t_mode[m][1])
			begin
				ec++;
				ev = 32'h2000_0000 + m;
				er = 32'h4000_0000 + m;
			end
			rdchk(`DIC_IDX_CAPT, `DIC_SUB_CAP_MODE, {30'h0, t_mode[m]});
			rdchk(`DIC_IDX_CAPT, `DIC_SUB_CAP_COUNT, ec);
			rdchk(`DIC_IDX_CAPT, `DIC_SUB_CAP_VALUE, ev);
			rdchk(`DIC_IDX_CAPT, `DIC_SUB_CAP_RAW, er);
		end
		wrap_up();
	end
endmodule
